// ==== core/serializer_general_mode_config.sv ====
// General configuration and mode select registers with their controlled logic
`timescale 1ns/10ps
`default_nettype none
module serializer_general_mode_config
#(
    parameter int PIXEL_W = 24,
    parameter int CRC_CNT_W = 8
)
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Serial control bus register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Port selection from the bridge control logic
    input wire logic second_port_select,
    // Local I2C transaction toward the link
    input wire logic fwd_req,
    input wire logic fwd_port,
    input wire logic fwd_is_write,
    input wire logic fwd_to_des,
    input wire logic fwd_alias_hit,
    input wire logic fwd_pass_all,
    input wire logic remote_ack,
    input wire logic remote_nack,
    output logic link_fwd,
    output logic local_ack,
    output logic local_nack,
    // Back-channel CRC
    input wire logic crc_error_event,
    output logic crc_check_enable,
    output logic [CRC_CNT_W-1:0] crc_error_count,
    // Clocking and failsafe
    input wire logic tmds_clk_present,
    output logic use_internal_osc,
    output logic failsafe_high,
    // Video pins
    input wire logic data_enable_input,
    input wire logic horizontal_sync_input,
    input wire logic vertical_sync_input,
    input wire logic [PIXEL_W-1:0] pixel_in,
    output logic de_out,
    output logic hs_out,
    output logic vs_out,
    output logic [PIXEL_W-1:0] pixel_out
);
    logic [7:0] gen_shared;
    logic [1:0] auto_ack;
    logic [1:0] pass_thru;
    logic [7:0] mode_sel;
    logic [7:0] next_gen_shared;
    logic [1:0] next_auto_ack;
    logic [1:0] next_pass_thru;
    logic [7:0] next_mode_sel;
    logic [7:0] next_rdata;
    logic [7:0] gen_view;

    // ======================================================================
    // Register file
    // Bits 5 and 3 are kept per port; the port select picks the copy seen.
    always_comb
    begin
        gen_view = gen_shared;
        gen_view[serializer_cfg_pkg::AUTO_ACK_BIT] = auto_ack[second_port_select];
        gen_view[serializer_cfg_pkg::PASS_THRU_BIT] = pass_thru[second_port_select];
    end

    always_comb
    begin
        next_gen_shared = gen_shared;
        next_auto_ack = auto_ack;
        next_pass_thru = pass_thru;
        next_mode_sel = mode_sel;
        next_rdata = reg_rdata;
        if (reg_write && (reg_addr == serializer_cfg_pkg::GEN_CFG_ADDR))
        begin
            // Reserved positions keep their reset value
            next_gen_shared = (gen_shared & ~serializer_cfg_pkg::GEN_SHARED_MASK)
                | (reg_wdata & serializer_cfg_pkg::GEN_SHARED_MASK);
            next_auto_ack[second_port_select] =
                reg_wdata[serializer_cfg_pkg::AUTO_ACK_BIT];
            next_pass_thru[second_port_select] =
                reg_wdata[serializer_cfg_pkg::PASS_THRU_BIT];
        end
        else if (reg_write && (reg_addr == serializer_cfg_pkg::MODE_SEL_ADDR))
        begin
            next_mode_sel = (mode_sel & ~serializer_cfg_pkg::MODE_WRITE_MASK)
                | (reg_wdata & serializer_cfg_pkg::MODE_WRITE_MASK);
        end
        if (reg_read)
        begin
            if (reg_addr == serializer_cfg_pkg::GEN_CFG_ADDR)
            begin
                next_rdata = gen_view;
            end
            else if (reg_addr == serializer_cfg_pkg::MODE_SEL_ADDR)
            begin
                next_rdata = mode_sel;
            end
            else
            begin
                next_rdata = serializer_cfg_pkg::UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            gen_shared <= serializer_cfg_pkg::GEN_CFG_RESET;
            auto_ack <= {2{serializer_cfg_pkg::GEN_CFG_RESET[serializer_cfg_pkg::AUTO_ACK_BIT]}};
            pass_thru <= {2{serializer_cfg_pkg::GEN_CFG_RESET[serializer_cfg_pkg::PASS_THRU_BIT]}};
            mode_sel <= serializer_cfg_pkg::MODE_SEL_RESET;
            reg_rdata <= 8'h00;
        end
        else if (ce)
        begin
            gen_shared <= next_gen_shared;
            auto_ack <= next_auto_ack;
            pass_thru <= next_pass_thru;
            mode_sel <= next_mode_sel;
            reg_rdata <= next_rdata;
        end
    end

    // ======================================================================
    // I2C forwarding and acknowledge
    serializer_cfg_pkg::fwd_state_t state;
    serializer_cfg_pkg::fwd_state_t next_state;
    logic next_link_fwd;
    logic next_local_ack;
    logic next_local_nack;
    logic req_forward;
    logic req_auto;

    always_comb
    begin
        req_forward = fwd_to_des || fwd_pass_all
            || (fwd_alias_hit && pass_thru[fwd_port]);
        req_auto = fwd_is_write && (fwd_to_des || fwd_pass_all)
            && auto_ack[fwd_port];
        next_state = state;
        next_link_fwd = 1'b0;
        next_local_ack = 1'b0;
        next_local_nack = 1'b0;
        case (state)
            serializer_cfg_pkg::FWD_IDLE:
            begin
                if (fwd_req && req_forward)
                begin
                    next_link_fwd = 1'b1;
                    if (req_auto)
                    begin
                        // Early ack trades error visibility for bus throughput
                        next_local_ack = 1'b1;
                        next_state = serializer_cfg_pkg::FWD_DISCARD;
                    end
                    else
                    begin
                        next_state = serializer_cfg_pkg::FWD_RELAY;
                    end
                end
            end
            serializer_cfg_pkg::FWD_RELAY:
            begin
                if (remote_ack)
                begin
                    next_local_ack = 1'b1;
                    next_state = serializer_cfg_pkg::FWD_IDLE;
                end
                else if (remote_nack)
                begin
                    next_local_nack = 1'b1;
                    next_state = serializer_cfg_pkg::FWD_IDLE;
                end
            end
            serializer_cfg_pkg::FWD_DISCARD:
            begin
                // Remote answer is swallowed, a failed write goes unseen
                if (remote_ack || remote_nack)
                begin
                    next_state = serializer_cfg_pkg::FWD_IDLE;
                end
            end
            default:
            begin
                next_state = serializer_cfg_pkg::FWD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state <= serializer_cfg_pkg::FWD_IDLE;
            link_fwd <= 1'b0;
            local_ack <= 1'b0;
            local_nack <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            link_fwd <= next_link_fwd;
            local_ack <= next_local_ack;
            local_nack <= next_local_nack;
        end
    end

    // ======================================================================
    // Back-channel CRC, clock switchover and failsafe
    logic [1:0] present_sync;
    logic [CRC_CNT_W-1:0] next_crc_count;
    logic next_osc;

    always_comb
    begin
        next_crc_count = crc_error_count;
        if (mode_sel[serializer_cfg_pkg::CRC_CLR_BIT])
        begin
            next_crc_count = '0;
        end
        else if (crc_error_event && gen_shared[serializer_cfg_pkg::CRC_EN_BIT]
            && (crc_error_count != {CRC_CNT_W{1'b1}}))
        begin
            next_crc_count = crc_error_count + CRC_CNT_W'(1);
        end
        next_osc = gen_shared[serializer_cfg_pkg::OSC_AUTO_BIT] && !present_sync[1];
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            present_sync <= 2'h0;
            crc_error_count <= '0;
            crc_check_enable <= 1'b0;
            use_internal_osc <= 1'b0;
            failsafe_high <= 1'b0;
        end
        else if (ce)
        begin
            present_sync <= {present_sync[0], tmds_clk_present};
            crc_error_count <= next_crc_count;
            crc_check_enable <= gen_shared[serializer_cfg_pkg::CRC_EN_BIT];
            use_internal_osc <= next_osc;
            failsafe_high <= !mode_sel[serializer_cfg_pkg::FAILSAFE_BIT];
        end
    end

    // ======================================================================
    // Video path: pixels delayed to match the sync filter latency
    video_filter_if vif ();
    logic [PIXEL_W-1:0] px_sync1;
    logic [PIXEL_W-1:0] px_sync2;
    logic [PIXEL_W-1:0] px_d1;
    logic [PIXEL_W-1:0] px_d2;
    logic [PIXEL_W-1:0] next_pixel_out;

    assign vif.raw = {vertical_sync_input, horizontal_sync_input, data_enable_input};
    assign vif.filter_en = gen_shared[serializer_cfg_pkg::FILTER_BIT];

    sync_glitch_filter u_filter (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .vif(vif)
    );

    always_comb
    begin
        next_pixel_out = px_d2;
        if (mode_sel[serializer_cfg_pkg::VIDEO_GATE_BIT] && !vif.filt[0])
        begin
            next_pixel_out = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            px_sync1 <= '0;
            px_sync2 <= '0;
            px_d1 <= '0;
            px_d2 <= '0;
            pixel_out <= '0;
            de_out <= 1'b0;
            hs_out <= 1'b0;
            vs_out <= 1'b0;
        end
        else if (ce)
        begin
            px_sync1 <= pixel_in;
            px_sync2 <= px_sync1;
            px_d1 <= px_sync2;
            px_d2 <= px_d1;
            pixel_out <= next_pixel_out;
            de_out <= vif.filt[0];
            hs_out <= vif.filt[1];
            vs_out <= vif.filt[2];
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_crc_enable_write: assert property (
        (ce && reg_write && reg_addr == serializer_cfg_pkg::GEN_CFG_ADDR) ##1 ce
        |=> (crc_check_enable == $past(reg_wdata[7], 2)))
        else $error("checker enable does not follow written bit");
    a_auto_ack_now: assert property (
        (ce && state == serializer_cfg_pkg::FWD_IDLE && fwd_req && req_auto)
        |=> (local_ack && link_fwd))
        else $error("auto acknowledge not given at once");
    a_nack_blocked: assert property (
        (ce && state == serializer_cfg_pkg::FWD_DISCARD && remote_nack)
        |=> (!local_nack && state == serializer_cfg_pkg::FWD_IDLE))
        else $error("remote nack reached master under auto ack");
    a_port_select: assert property (
        (ce && reg_write && second_port_select
            && reg_addr == serializer_cfg_pkg::GEN_CFG_ADDR)
        |=> (auto_ack[1] == $past(reg_wdata[5]) && auto_ack[0] == $past(auto_ack[0])))
        else $error("port one write leaked into port zero");
    a_passthru_fwd: assert property (
        (ce && state == serializer_cfg_pkg::FWD_IDLE && fwd_req
            && fwd_alias_hit && pass_thru[fwd_port])
        |=> link_fwd)
        else $error("alias match not forwarded");
    a_osc_switch: assert property (
        (ce && gen_shared[1] && !present_sync[1]) |=> use_internal_osc)
        else $error("no switch to internal oscillator");
    a_failsafe_level: assert property (
        (ce && reg_write && reg_addr == serializer_cfg_pkg::MODE_SEL_ADDR) ##1 ce
        |=> (failsafe_high == !$past(reg_wdata[7], 2)))
        else $error("failsafe level wrong");
    a_crc_hold_clear: assert property (
        (ce && mode_sel[5]) [*2] |-> (crc_error_count == '0))
        else $error("counter not held clear");
    a_video_gate: assert property (
        (ce && mode_sel[4]) |=> (de_out || pixel_out == '0))
        else $error("pixel data leaked during blanking");
    a_reserved_read: assert property (
        (ce && reg_read && reg_addr == serializer_cfg_pkg::GEN_CFG_ADDR)
        |=> (reg_rdata[6] && !reg_rdata[2] && !reg_rdata[0]))
        else $error("reserved bits read wrong");

    c_auto_ack: cover property (ce && fwd_req && req_auto
        && state == serializer_cfg_pkg::FWD_IDLE);
    c_relay_nack: cover property (ce && state == serializer_cfg_pkg::FWD_RELAY && remote_nack);
    c_gated: cover property (mode_sel[4] && !de_out && px_d2 != '0);
    c_osc: cover property ($rose(use_internal_osc));
endmodule
`default_nettype wire

// ==== core/sync_glitch_filter.sv ====
// Synchroniser and two-clock glitch filter for sync and data-enable inputs
`timescale 1ns/10ps
`default_nettype none
module sync_glitch_filter
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Levels
    video_filter_if.filter vif
);
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] hist;
    logic [2:0] filt_level;
    logic [2:0] next_hist;
    logic [2:0] next_filt;

    // ======================================================================
    // Filter: a level passes only once seen on two successive samples.
    // The unfiltered path keeps the same latency so pixel alignment holds.
    always_comb
    begin
        next_hist = sync2;
        next_filt = filt_level;
        for (int i = 0; i < 3; i++)
        begin
            if (!vif.filter_en || (sync2[i] == hist[i]))
            begin
                next_filt[i] = hist[i];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            hist <= 3'h0;
            filt_level <= 3'h0;
        end
        else if (ce)
        begin
            sync1 <= vif.raw;
            sync2 <= sync1;
            hist <= next_hist;
            filt_level <= next_filt;
        end
    end

    assign vif.filt = filt_level;

    // ======================================================================
    // Checks
    a_filter_reject: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && $past(ce) && $past(vif.filter_en) && $rose(filt_level[0]))
        |-> ($past(hist[0]) && $past(sync2[0])))
        else $error("filtered enable rose without two equal samples");
endmodule
`default_nettype wire

// ==== dv/remote_des_model.sv ====
// Behavioural remote deserializer answering forwarded control transactions
`timescale 1ns/10ps
`default_nettype none
module remote_des_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Link side
    input wire logic link_fwd,
    output logic remote_ack,
    output logic remote_nack,
    // Behaviour chosen by the bench
    input wire logic [3:0] delay,
    input wire logic answer_nack
);
    int wait_n;

    // ======================================================================
    // Answer
    // Launched on the falling edge so the core samples a settled pulse
    always @(negedge mclk)
    begin
        // One assignment per signal per edge; a reload outranks a due answer
        remote_ack <= rstn && !link_fwd && (wait_n == 1) && !answer_nack;
        remote_nack <= rstn && !link_fwd && (wait_n == 1) && answer_nack;
        if (!rstn)
            wait_n <= 0;
        else if (link_fwd)
            wait_n <= int'(delay) + 1;
        else if (wait_n > 0)
            wait_n <= wait_n - 1;
    end
endmodule
`default_nettype wire

// ==== dv/serializer_general_mode_config_test.sv ====
// Self-checking bench for the general and mode configuration registers
`timescale 1ns/10ps
`default_nettype none
module serializer_general_mode_config_test;
    typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} row_t;
    logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
    logic reg_write = 1'b0, reg_read = 1'b0, second_port_select = 1'b0;
    logic fwd_req = 1'b0, fwd_port = 1'b0, fwd_is_write = 1'b0, fwd_to_des = 1'b0;
    logic fwd_alias_hit = 1'b0, fwd_pass_all = 1'b0, remote_ack, remote_nack;
    logic link_fwd, local_ack, local_nack, crc_error_event = 1'b0, crc_check_enable;
    logic [7:0] crc_error_count;
    logic tmds_clk_present = 1'b1, use_internal_osc, failsafe_high;
    logic data_enable_input = 1'b0, horizontal_sync_input = 1'b0;
    logic vertical_sync_input = 1'b0, de_out, hs_out, vs_out;
    logic [23:0] pixel_in = 24'hA5A5A5, pixel_out;
    logic [3:0] delay = 4'h3;
    logic answer_nack = 1'b1;
    int errors = 0, checks = 0;
    int n_fwd = 0, n_ack = 0, n_nack = 0, n_both = 0, n_de = 0, n_hs = 0, n_vs = 0;
    // Reserved bits hold their reset level whatever is written
    row_t rows [7] = '{'{8'h03, 8'h00, 8'h40}, '{8'h03, 8'hFF, 8'hFA},
        '{8'h04, 8'hFF, 8'hB0}, '{8'h04, 8'h00, 8'h00}, '{8'h05, 8'hFF, 8'h00},
        '{8'h03, 8'hD2, 8'hD2}, '{8'h04, 8'h80, 8'h80}};

    always #2.5 mclk = ~mclk;

    serializer_general_mode_config dut_u (.mclk(mclk), .rstn(rstn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .second_port_select(second_port_select),
        .fwd_req(fwd_req), .fwd_port(fwd_port), .fwd_is_write(fwd_is_write),
        .fwd_to_des(fwd_to_des), .fwd_alias_hit(fwd_alias_hit), .fwd_pass_all(fwd_pass_all),
        .remote_ack(remote_ack), .remote_nack(remote_nack), .link_fwd(link_fwd),
        .local_ack(local_ack), .local_nack(local_nack), .crc_error_event(crc_error_event),
        .crc_check_enable(crc_check_enable), .crc_error_count(crc_error_count),
        .tmds_clk_present(tmds_clk_present), .use_internal_osc(use_internal_osc),
        .failsafe_high(failsafe_high), .data_enable_input(data_enable_input),
        .horizontal_sync_input(horizontal_sync_input),
        .vertical_sync_input(vertical_sync_input), .pixel_in(pixel_in),
        .de_out(de_out), .hs_out(hs_out), .vs_out(vs_out), .pixel_out(pixel_out));

    remote_des_model des_u (.mclk(mclk), .rstn(rstn), .link_fwd(link_fwd),
        .remote_ack(remote_ack), .remote_nack(remote_nack), .delay(delay),
        .answer_nack(answer_nack));

    // ======================================================================
    // Pulse monitors, sampled mid-cycle where the registered pulses are settled
    always @(negedge mclk)
    begin
        n_fwd += int'(link_fwd === 1'b1);
        n_ack += int'(local_ack === 1'b1);
        n_nack += int'(local_nack === 1'b1);
        n_both += int'(link_fwd === 1'b1 && local_ack === 1'b1);
        n_de += int'(de_out === 1'b1);
        n_hs += int'(hs_out === 1'b1);
        n_vs += int'(vs_out === 1'b1);
    end

    // ======================================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        tick(1);
        reg_write = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_read = 1'b1;
        tick(1);
        reg_read = 1'b0;
        tick(1);
        rd_val = reg_rdata;
    endtask

    // Fields: port, write, to remote, alias hit, forward all
    task automatic fwd(input logic [4:0] f, input int e_fwd, e_ack, e_nack, e_both);
        int s0, s1, s2, s3;
        s0 = n_fwd;
        s1 = n_ack;
        s2 = n_nack;
        s3 = n_both;
        {fwd_port, fwd_is_write, fwd_to_des, fwd_alias_hit, fwd_pass_all} = f;
        fwd_req = 1'b1;
        tick(1);
        fwd_req = 1'b0;
        tick(10);
        check(n_fwd - s0, e_fwd);
        check(n_ack - s1, e_ack);
        check(n_nack - s2, e_nack);
        check(n_both - s3, e_both);
    endtask

    task automatic vpulse(input int w, input logic exp);
        int s0, s1, s2;
        s0 = n_de;
        s1 = n_hs;
        s2 = n_vs;
        {data_enable_input, horizontal_sync_input, vertical_sync_input} = 3'h7;
        tick(w);
        {data_enable_input, horizontal_sync_input, vertical_sync_input} = 3'h0;
        tick(8);
        check(n_de != s0, exp);
        check(n_hs != s1, exp);
        check(n_vs != s2, exp);
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        tick(2);
        rstn = 1'b1;
        tick(1);
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            check(rd_val, rows[i].rexp);
        end
        // Mid-run reset after writes of 00 and 30 have disturbed both registers
        wr(8'h03, 8'h00);
        wr(8'h04, 8'h30);
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(2);
        rd(8'h03);
        check(rd_val, 8'hD2);
        rd(8'h04);
        check(rd_val, 8'h80);
        check(crc_check_enable, 1'b1);
        check(failsafe_high, 1'b0);
        wr(8'h04, 8'h00);
        tick(1);
        check(failsafe_high, 1'b1);
        wr(8'h04, 8'h80);
        ce = 1'b0;
        wr(8'h03, 8'h00);
        ce = 1'b1;
        rd(8'h03);
        check(rd_val, 8'hD2);
        second_port_select = 1'b1;
        wr(8'h03, 8'hFA);
        rd(8'h03);
        check(rd_val, 8'hFA);
        second_port_select = 1'b0;
        rd(8'h03);
        check(rd_val, 8'hD2);
        // Port 1 now auto-acknowledges and passes through; port 0 does neither
        fwd(5'b01100, 1, 0, 1, 0);
        fwd(5'b11100, 1, 1, 0, 1);
        fwd(5'b11001, 1, 1, 0, 1);
        delay = 4'h0;
        answer_nack = 1'b0;
        fwd(5'b10100, 1, 1, 0, 0);
        fwd(5'b01010, 0, 0, 0, 0);
        fwd(5'b10010, 1, 1, 0, 0);
        fwd(5'b11010, 1, 1, 0, 0);
        crc_error_event = 1'b1;
        tick(3);
        crc_error_event = 1'b0;
        tick(2);
        check(crc_error_count, 8'h03);
        wr(8'h04, 8'hA0);
        check(crc_error_count, 8'h00);
        crc_error_event = 1'b1;
        tick(2);
        crc_error_event = 1'b0;
        tick(2);
        check(crc_error_count, 8'h00);
        rd(8'h04);
        check(rd_val, 8'hA0);
        wr(8'h04, 8'h80);
        wr(8'h03, 8'h52);
        check(crc_check_enable, 1'b0);
        crc_error_event = 1'b1;
        tick(2);
        crc_error_event = 1'b0;
        tick(2);
        check(crc_error_count, 8'h00);
        wr(8'h03, 8'hD2);
        tmds_clk_present = 1'b0;
        tick(6);
        check(use_internal_osc, 1'b1);
        wr(8'h03, 8'hD0);
        tick(3);
        check(use_internal_osc, 1'b0);
        wr(8'h03, 8'hD2);
        tmds_clk_present = 1'b1;
        tick(6);
        check(use_internal_osc, 1'b0);
        vpulse(1, 1'b0);
        vpulse(3, 1'b1);
        vpulse(2, 1'b1);
        wr(8'h03, 8'hC2);
        vpulse(1, 1'b1);
        wr(8'h03, 8'hD2);
        tick(8);
        check(pixel_out, 24'hA5A5A5);
        wr(8'h04, 8'h90);
        tick(8);
        check(pixel_out, 24'h000000);
        data_enable_input = 1'b1;
        tick(8);
        check(pixel_out, 24'hA5A5A5);
        data_enable_input = 1'b0;
        close_out();
    end

    // ======================================================================
    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #20000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire

// ==== pkg/serializer_cfg_pkg.sv ====
// Constants and types shared by the general and mode configuration registers
package serializer_cfg_pkg;

    // ======================================================================
    // Register map
    localparam logic [7:0] GEN_CFG_ADDR = 8'h03;
    localparam logic [7:0] MODE_SEL_ADDR = 8'h04;
    localparam logic [7:0] GEN_CFG_RESET = 8'hD2;
    localparam logic [7:0] MODE_SEL_RESET = 8'h80;

    // ======================================================================
    // Field positions
    localparam int CRC_EN_BIT = 7;
    localparam int AUTO_ACK_BIT = 5;
    localparam int FILTER_BIT = 4;
    localparam int PASS_THRU_BIT = 3;
    localparam int OSC_AUTO_BIT = 1;
    localparam int FAILSAFE_BIT = 7;
    localparam int CRC_CLR_BIT = 5;
    localparam int VIDEO_GATE_BIT = 4;

    // Bits stored once for both ports; bits 5 and 3 live per port
    localparam logic [7:0] GEN_SHARED_MASK = 8'h92;
    localparam logic [7:0] MODE_WRITE_MASK = 8'hB0;

    // ======================================================================
    // Counts and states
    localparam int FILTER_MIN_CYCLES = 2;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [1:0] {FWD_IDLE, FWD_RELAY, FWD_DISCARD} fwd_state_t;

endpackage

// ==== pkg/video_filter_if.sv ====
// Carrier of sync and data-enable levels between the core and its filter
`timescale 1ns/10ps
`default_nettype none
interface video_filter_if;
    // Bit 0 data enable, bit 1 horizontal sync, bit 2 vertical sync
    logic [2:0] raw;
    logic [2:0] filt;
    logic filter_en;
    modport filter (input raw, input filter_en, output filt);
    modport user (output raw, output filter_en, input filt);
endinterface
`default_nettype wire
